// file: include/icu_defines.vh
// Constants of the input capture unit: register offsets, field positions,
// mode codes and reset values.
// Assumes a 32-bit APB slave with one register per aligned word.
`ifndef ICU_DEFINES_VH
`define ICU_DEFINES_VH

// ------------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------------
`define ICU_OFS_CTRL 12'h000
`define ICU_OFS_BUF 12'h004
`define ICU_OFS_IRQ_STAT 12'h008
`define ICU_OFS_IRQ_MASK 12'h00C
`define ICU_OFS_PWR 12'h010

// ------------------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------------------
`define ICU_BIT_IDLE_STOP 13
`define ICU_BIT_TMR_SEL 7
`define ICU_BIT_CPI_HI 6
`define ICU_BIT_CPI_LO 5
`define ICU_BIT_OVF 4
`define ICU_BIT_BNE 3
`define ICU_BIT_MODE_HI 2
`define ICU_BIT_MODE_LO 0

// ------------------------------------------------------------------------
// Mode codes
// ------------------------------------------------------------------------
`define ICU_MODE_OFF 3'h0
`define ICU_MODE_BOTH 3'h1
`define ICU_MODE_FALL 3'h2
`define ICU_MODE_RISE 3'h3
`define ICU_MODE_RISE4 3'h4
`define ICU_MODE_RISE16 3'h5
`define ICU_MODE_UNUSED 3'h6
`define ICU_MODE_WAKE 3'h7

// ------------------------------------------------------------------------
// Interrupt status bits, reset values, counts
// ------------------------------------------------------------------------
`define ICU_IRQ_CAP 0
`define ICU_IRQ_OVF 1
`define ICU_IRQ_WAKE 2
`define ICU_CTRL_RST 16'h0000
`define ICU_IRQ_RST 3'h0
`define ICU_PRE4_LAST 4'h3
`define ICU_PRE16_LAST 4'hF
`define ICU_PMD_DELAY 2'h1

`endif

// file: hdl/icu_top.v
// Input capture unit: APB register slave, pin synchroniser, edge detector,
// prescaler, four-entry capture buffer, interrupt status and mask.
// Assumes timer counts and power-state levels are synchronous to CLK_SYS_I.
`timescale 1ns/1ps
`include "icu_defines.vh"
`default_nettype none

module icu_top #(
   parameter TMR_W = 16,
   parameter DEPTH = 4,
   parameter PTR_W = 2
)
(
   // Clock and reset.
   input wire CLK_SYS_I,
   input wire RST_N_I,
   // APB slave.
   input wire PSEL_I,
   input wire PENABLE_I,
   input wire PWRITE_I,
   input wire [11:0] PADDR_I,
   input wire [31:0] PWDATA_I,
   output reg [31:0] PRDATA_O,
   output reg PREADY_O,
   output reg PSLVERR_O,
   // Capture pin, timers and power state.
   input wire CAP_PIN_I,
   input wire [TMR_W-1:0] SECOND_TIMER_COUNT_I,
   input wire [TMR_W-1:0] THIRD_TIMER_COUNT_I,
   input wire CPU_IDLE_I,
   input wire CPU_SLEEP_I,
   // Interrupt and wake.
   output reg IRQ_O,
   output reg WAKE_O
);

   // ---------------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------------
   // Pointer increment wrapping at the buffer depth.
   function [PTR_W-1:0] ptr_inc;
      input [PTR_W-1:0] p;
      begin
         ptr_inc = p + {{(PTR_W-1){1'b0}}, 1'b1};
      end
   endfunction

   // ---------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------
   reg idle_stop_select;
   reg timer_source_select;
   reg [1:0] captures_per_interrupt;
   reg [2:0] capture_mode_select;
   reg capture_overflow_flag;
   reg module_clock_disable;
   reg [1:0] pmd_pipe;
   reg [2:0] irq_stat;
   reg [2:0] irq_mask;
   reg pin_s1;
   reg pin_s2;
   reg pin_d;
   reg [3:0] pre_cnt;
   reg [1:0] cpi_cnt;
   reg [TMR_W-1:0] fifo [0:DEPTH-1];
   reg [PTR_W-1:0] wr_ptr;
   reg [PTR_W-1:0] rd_ptr;
   reg [PTR_W:0] fill;
   // Set when a buffer read returned a real entry, so only that read pops.
   reg buf_rd_ok;

   // ---------------------------------------------------------------------
   // Decodes
   // ---------------------------------------------------------------------
   wire apb_acc = PSEL_I & PENABLE_I & PREADY_O;
   wire apb_wr = apb_acc & PWRITE_I;
   wire apb_rd = apb_acc & ~PWRITE_I;
   // The unit is gated from the delayed copy of the disable bit.
   wire unit_off = pmd_pipe[1];
   wire wr_ctrl = apb_wr & ~unit_off & (PADDR_I == `ICU_OFS_CTRL);
   // A capture landing between the data cycle and the ready edge must not be popped unread.
   wire rd_buf = apb_rd & buf_rd_ok & (PADDR_I == `ICU_OFS_BUF);
   wire halted = unit_off | (idle_stop_select & CPU_IDLE_I);
   wire rise = pin_s2 & ~pin_d;
   wire fall = ~pin_s2 & pin_d;
   wire buf_empty = (fill == {(PTR_W+1){1'b0}});
   wire buf_full = (fill == DEPTH[PTR_W:0]);

   // Edge selection by mode; off, unused and wake modes never capture.
   reg edge_hit;
   reg pre_wrap;
   always @*
   begin
      edge_hit = 1'b0;
      pre_wrap = 1'b0;
      case (capture_mode_select)
         `ICU_MODE_BOTH: edge_hit = rise | fall;
         `ICU_MODE_FALL: edge_hit = fall;
         `ICU_MODE_RISE: edge_hit = rise;
         `ICU_MODE_RISE4:
         begin
            edge_hit = rise;
            pre_wrap = (pre_cnt == `ICU_PRE4_LAST);
         end
         `ICU_MODE_RISE16:
         begin
            edge_hit = rise;
            pre_wrap = (pre_cnt == `ICU_PRE16_LAST);
         end
         default:
         begin
            edge_hit = 1'b0;
            pre_wrap = 1'b0;
         end
      endcase
   end

   wire use_pre = (capture_mode_select == `ICU_MODE_RISE4) |
                  (capture_mode_select == `ICU_MODE_RISE16);
   wire cap_evt = ~halted & edge_hit & (~use_pre | pre_wrap);
   wire cap_ovf = cap_evt & buf_full & ~rd_buf;
   wire cap_push = cap_evt & ~cap_ovf;
   wire cap_pop = rd_buf & ~buf_empty;
   wire cpi_hit = (capture_mode_select == `ICU_MODE_BOTH) |
                  (cpi_cnt == captures_per_interrupt);
   // Wake source: rising edge only, only in Sleep or Idle, other bits ignored.
   wire wake_evt = ~unit_off & (capture_mode_select == `ICU_MODE_WAKE) &
                   rise & (CPU_SLEEP_I | CPU_IDLE_I);
   wire [2:0] irq_set = {wake_evt, cap_ovf, cap_evt & cpi_hit};
   wire [TMR_W-1:0] cap_val = timer_source_select ? SECOND_TIMER_COUNT_I :
                              THIRD_TIMER_COUNT_I;

   // ---------------------------------------------------------------------
   // Pin synchroniser and edge history
   // ---------------------------------------------------------------------
   // The first stage feeds only the second; edges are seen on stage two.
   always @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         pin_d <= 1'b0;
      end
      else
      begin
         pin_s1 <= CAP_PIN_I;
         pin_s2 <= pin_s1;
         pin_d <= pin_s2;
      end
   end

   // ---------------------------------------------------------------------
   // Control register and clock-disable bit
   // ---------------------------------------------------------------------
   // The disable bit is always writable, else the unit could never return.
   always @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         idle_stop_select <= 1'b0;
         timer_source_select <= 1'b0;
         captures_per_interrupt <= 2'h0;
         capture_mode_select <= `ICU_MODE_OFF;
         module_clock_disable <= 1'b0;
         pmd_pipe <= 2'h0;
      end
      else
      begin
         pmd_pipe <= {pmd_pipe[0], module_clock_disable};
         if (apb_wr && PADDR_I == `ICU_OFS_PWR)
            module_clock_disable <= PWDATA_I[0];
         if (wr_ctrl)
         begin
            idle_stop_select <= PWDATA_I[`ICU_BIT_IDLE_STOP];
            timer_source_select <= PWDATA_I[`ICU_BIT_TMR_SEL];
            captures_per_interrupt <= PWDATA_I[`ICU_BIT_CPI_HI:`ICU_BIT_CPI_LO];
            capture_mode_select <= PWDATA_I[`ICU_BIT_MODE_HI:`ICU_BIT_MODE_LO];
         end
      end
   end

   // ---------------------------------------------------------------------
   // Prescaler and captures-per-interrupt counter
   // ---------------------------------------------------------------------
   // Both restart on any control write taken while enabled so a new mode starts clean.
   always @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         pre_cnt <= 4'h0;
         cpi_cnt <= 2'h0;
      end
      else if (wr_ctrl)
      begin
         pre_cnt <= 4'h0;
         cpi_cnt <= 2'h0;
      end
      else
      begin
         if (~halted && use_pre && rise)
            pre_cnt <= pre_wrap ? 4'h0 : pre_cnt + 4'h1;
         if (cap_evt)
            cpi_cnt <= cpi_hit ? 2'h0 : cpi_cnt + 2'h1;
      end
   end

   // ---------------------------------------------------------------------
   // Capture buffer
   // ---------------------------------------------------------------------
   // A full buffer keeps its old entries; the newest capture is lost.
   always @(posedge CLK_SYS_I)
   begin
      if (cap_push)
         fifo[wr_ptr] <= cap_val;
   end

   always @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         wr_ptr <= {PTR_W{1'b0}};
         rd_ptr <= {PTR_W{1'b0}};
         fill <= {(PTR_W+1){1'b0}};
         capture_overflow_flag <= 1'b0;
      end
      else
      begin
         if (cap_push)
            wr_ptr <= ptr_inc(wr_ptr);
         if (cap_pop)
            rd_ptr <= ptr_inc(rd_ptr);
         if (cap_push && !cap_pop)
            fill <= fill + {{PTR_W{1'b0}}, 1'b1};
         else if (cap_pop && !cap_push)
            fill <= fill - {{PTR_W{1'b0}}, 1'b1};
         // Set wins; the flag clears by hardware once the buffer drains.
         if (cap_ovf)
            capture_overflow_flag <= 1'b1;
         else if (cap_pop && fill == {{PTR_W{1'b0}}, 1'b1})
            capture_overflow_flag <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------
   // Interrupt status, mask and outputs
   // ---------------------------------------------------------------------
   // Write-one-to-clear; a same-cycle event keeps its bit set.
   always @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         irq_stat <= `ICU_IRQ_RST;
         irq_mask <= `ICU_IRQ_RST;
         IRQ_O <= 1'b0;
         WAKE_O <= 1'b0;
      end
      else
      begin
         if (apb_wr && !unit_off && PADDR_I == `ICU_OFS_IRQ_STAT)
            irq_stat <= (irq_stat & ~PWDATA_I[2:0]) | irq_set;
         else
            irq_stat <= irq_stat | irq_set;
         if (apb_wr && !unit_off && PADDR_I == `ICU_OFS_IRQ_MASK)
            irq_mask <= PWDATA_I[2:0];
         IRQ_O <= |(irq_stat & irq_mask);
         WAKE_O <= |(irq_stat & irq_mask) & (CPU_IDLE_I | CPU_SLEEP_I);
      end
   end

   // ---------------------------------------------------------------------
   // APB answer
   // ---------------------------------------------------------------------
   // One wait state: PREADY rises in the second access cycle, then drops.
   // While disabled, unit registers other than the power register read as zero (their value is invalid).
   always @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         PREADY_O <= 1'b0;
         PRDATA_O <= 32'h0000_0000;
         PSLVERR_O <= 1'b0;
         buf_rd_ok <= 1'b0;
      end
      else
      begin
         PREADY_O <= PSEL_I & PENABLE_I & ~PREADY_O;
         PSLVERR_O <= 1'b0;
         PRDATA_O <= 32'h0000_0000;
         buf_rd_ok <= 1'b0;
         if (PSEL_I && PENABLE_I && !PREADY_O)
         begin
            case (PADDR_I)
               `ICU_OFS_CTRL:
                  if (!unit_off)
                     PRDATA_O <= {18'h0, idle_stop_select, 5'h0,
                                  timer_source_select, captures_per_interrupt,
                                  capture_overflow_flag, ~buf_empty,
                                  capture_mode_select};
               `ICU_OFS_BUF:
                  if (!unit_off && !buf_empty)
                  begin
                     PRDATA_O <= {{(32-TMR_W){1'b0}}, fifo[rd_ptr]};
                     buf_rd_ok <= 1'b1;
                  end
               `ICU_OFS_IRQ_STAT:
                  if (!unit_off)
                     PRDATA_O <= {29'h0, irq_stat};
               `ICU_OFS_IRQ_MASK:
                  if (!unit_off)
                     PRDATA_O <= {29'h0, irq_mask};
               `ICU_OFS_PWR:
                  PRDATA_O <= {31'h0, module_clock_disable};
               default:
                  PSLVERR_O <= 1'b1;
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// file: sim/icu_chk.sv
// Checker of the capture unit's bus, interrupt and wake ports.
// Assumes it is bound into icu_top and sees only that module's ports.
`timescale 1ns/1ps
`include "icu_defines.vh"
`default_nettype none
module icu_chk
(
   // Clock and reset.
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   // Bus.
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   // Power state, interrupt and wake.
   input wire logic CPU_IDLE_I,
   input wire logic CPU_SLEEP_I,
   input wire logic IRQ_O,
   input wire logic WAKE_O
);
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RST_N_I);
   // ----------------------------------------------------------------
   // Bus timing and decode.
   // ----------------------------------------------------------------
   ready_wait_a: assert property (PSEL_I && PENABLE_I && !$past(PENABLE_I)
      |-> !PREADY_O ##1 PREADY_O) else $error("ready not one wait state");
   ready_pulse_a: assert property (PREADY_O |=> !PREADY_O) else $error("ready too long");
   ready_cause_a: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
      else $error("ready without access");
   rdata_idle_a: assert property (!PREADY_O |-> PRDATA_O == 32'h0000_0000)
      else $error("read data outside answer");
   slverr_map_a: assert property (PREADY_O |-> PSLVERR_O == !(PADDR_I inside {`ICU_OFS_CTRL,
      `ICU_OFS_BUF, `ICU_OFS_IRQ_STAT, `ICU_OFS_IRQ_MASK, `ICU_OFS_PWR}))
      else $error("error flag wrong for address");
   // Unimplemented control bits always read back as zero.
   ctrl_unimpl_a: assert property (PREADY_O && !PWRITE_I && PADDR_I == `ICU_OFS_CTRL
      |-> PRDATA_O[31:14] == 0 && PRDATA_O[12:8] == 0) else $error("control spare bits set");
   stat_width_a: assert property (PREADY_O && !PWRITE_I && PADDR_I == `ICU_OFS_IRQ_STAT
      |-> PRDATA_O[31:3] == 0) else $error("status spare bits set");
   // ----------------------------------------------------------------
   // Wake and reset.
   // ----------------------------------------------------------------
   wake_cause_a: assert property (WAKE_O |-> $past(CPU_IDLE_I || CPU_SLEEP_I))
      else $error("wake while running");
   reset_quiet_a: assert property ($rose(RST_N_I) |-> !IRQ_O && !WAKE_O && !PREADY_O)
      else $error("outputs active after reset");
   wake_c: cover property ($rose(WAKE_O));
   irq_c: cover property ($rose(IRQ_O));
   slverr_c: cover property (PSLVERR_O);
endmodule
bind icu_top icu_chk u_chk (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CPU_IDLE_I(CPU_IDLE_I),
   .CPU_SLEEP_I(CPU_SLEEP_I), .IRQ_O(IRQ_O), .WAKE_O(WAKE_O));
`default_nettype wire

// file: sim/icu_far.sv
// Far side of the capture unit: the capture pin and the two timers.
// Assumes the bench pulses step_i; each step toggles the pin and advances
// both timers, so counts stay still while a capture is being taken.
`timescale 1ns/1ps
`default_nettype none
module icu_far
(
   // Clock and command.
   input wire logic clk_i,
   input wire logic step_i,
   // Pin and timer counts.
   output logic pin_o,
   output logic [15:0] sec_o,
   output logic [15:0] thr_o
);
   logic [15:0] cnt = 16'h0000;
   logic pin_q = 1'b0;
   // Pin stands still between steps; the two timers differ in every count.
   always @(posedge clk_i)
   begin
      if (step_i)
      begin
         pin_q <= ~pin_q;
         cnt <= cnt + 16'h0001;
      end
   end
   assign pin_o = pin_q;
   assign sec_o = cnt;
   assign thr_o = cnt ^ 16'h5a5a;
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench of the capture unit over its bus.
// Assumes icu_top, icu_far and the bound checker are compiled with it.
`timescale 1ns/1ps
`include "icu_defines.vh"
`default_nettype none
module tb_top;
   typedef struct {logic [2:0] mode; logic tsel; int ntog; int ncap; int first;} icu_row_t;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic step = 1'b0, idle = 1'b0, sleep = 1'b0, pin, slverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, rdata;
   logic [15:0] sec, thr, nst = 16'h0000, base, first;
   wire [31:0] prdata;
   wire pready, perr, irq, wake;
   int n_mismatch = 0, n_tests = 0, cnt;
   icu_row_t rows [8] = '{
      '{`ICU_MODE_BOTH, 1'b1, 4, 4, 1},
      '{`ICU_MODE_FALL, 1'b0, 4, 2, 2},
      '{`ICU_MODE_RISE, 1'b1, 4, 2, 1},
      '{`ICU_MODE_RISE4, 1'b0, 8, 1, 7},
      '{`ICU_MODE_RISE16, 1'b1, 32, 1, 31},
      '{`ICU_MODE_OFF, 1'b0, 4, 0, 0},
      '{`ICU_MODE_UNUSED, 1'b1, 4, 0, 0},
      '{`ICU_MODE_WAKE, 1'b0, 4, 0, 0}};
   always #2.5 clk = ~clk;
   icu_far far (.clk_i(clk), .step_i(step), .pin_o(pin), .sec_o(sec), .thr_o(thr));
   icu_top dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(perr), .CAP_PIN_I(pin), .SECOND_TIMER_COUNT_I(sec),
      .THIRD_TIMER_COUNT_I(thr), .CPU_IDLE_I(idle), .CPU_SLEEP_I(sleep), .IRQ_O(irq),
      .WAKE_O(wake));
   // ----------------------------------------------------------------
   // Tasks.
   // ----------------------------------------------------------------
   // One bus transfer; the request stands until the edge that samples ready high,
   // and read data and error are taken at that same edge before release.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && k < 20)
      begin
         @(posedge clk);
         k++;
      end
      if (k == 20)
         n_mismatch++;
      rdata = prdata;
      slverr = perr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Toggles the pin n times, leaving room for synchroniser and capture.
   task tog(input int n);
      repeat (n)
      begin
         @(posedge clk);
         step <= 1'b1;
         @(posedge clk);
         step <= 1'b0;
         nst++;
         repeat (8) @(posedge clk);
      end
      @(negedge clk);
   endtask
   // Pops the buffer while not-empty shows; bounded so a stuck flag ends.
   task drain();
      cnt = 0;
      apb(1'b0, `ICU_OFS_CTRL, 0);
      while (rdata[3] === 1'b1 && cnt < 6)
      begin
         apb(1'b0, `ICU_OFS_BUF, 0);
         if (cnt == 0)
            first = rdata[15:0];
         cnt++;
         apb(1'b0, `ICU_OFS_CTRL, 0);
      end
   endtask
   task report_and_stop;
      if (n_mismatch == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog well past the expected run of about 1400 cycles.
   initial
   begin
      #100000;
      n_mismatch++;
      report_and_stop;
   end
   // ----------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, `ICU_OFS_PWR, 0);
      chk_val("pwr reset", 0, rdata);
      apb(1'b1, `ICU_OFS_CTRL, 32'h0000_0018);
      apb(1'b0, `ICU_OFS_CTRL, 0);
      chk_val("ctrl ro", 0, rdata);
      foreach (rows[i])
      begin
         base = nst + 16'(rows[i].first);
         apb(1'b1, `ICU_OFS_CTRL, {24'h00_0000, rows[i].tsel, 4'h0, rows[i].mode});
         tog(rows[i].ntog);
         drain();
         chk_val("captures", rows[i].ncap, cnt);
         if (rows[i].ncap > 0)
            chk_val("first", rows[i].tsel ? base : base ^ 16'h5a5a, first);
      end
      base = nst + 16'h0001;
      apb(1'b1, `ICU_OFS_CTRL, 32'h0000_0003);
      tog(10);
      apb(1'b0, `ICU_OFS_CTRL, 0);
      chk_val("overflow", 32'h0000_001B, rdata);
      drain();
      chk_val("kept", 4, cnt);
      chk_val("oldest", base ^ 16'h5a5a, first);
      apb(1'b1, `ICU_OFS_IRQ_STAT, 32'h0000_0007);
      apb(1'b1, `ICU_OFS_IRQ_MASK, 32'h0000_0001);
      apb(1'b1, `ICU_OFS_CTRL, 32'h0000_0063);
      tog(6);
      chk_val("irq third", 0, irq);
      tog(2);
      chk_val("irq fourth", 1, irq);
      apb(1'b1, `ICU_OFS_IRQ_STAT, 32'h0000_0001);
      apb(1'b1, `ICU_OFS_IRQ_MASK, 32'h0000_0000);
      drain();
      tog(8);
      chk_val("irq masked", 0, irq);
      apb(1'b1, `ICU_OFS_IRQ_MASK, 32'h0000_0001);
      repeat (3) @(negedge clk);
      chk_val("irq unmasked", 1, irq);
      apb(1'b1, `ICU_OFS_IRQ_STAT, 32'h0000_0007);
      drain();
      idle <= 1'b1;
      apb(1'b1, `ICU_OFS_CTRL, 32'h0000_2003);
      tog(2);
      apb(1'b0, `ICU_OFS_CTRL, 0);
      chk_val("idle stop", 32'h0000_2003, rdata);
      idle <= 1'b0;
      tog(2);
      apb(1'b0, `ICU_OFS_CTRL, 0);
      chk_val("idle run", 32'h0000_200B, rdata);
      drain();
      apb(1'b1, `ICU_OFS_IRQ_MASK, 32'h0000_0004);
      apb(1'b1, `ICU_OFS_CTRL, 32'h0000_0007);
      sleep <= 1'b1;
      tog(2);
      chk_val("wake", 1, wake);
      chk_val("wake irq", 1, irq);
      apb(1'b0, `ICU_OFS_IRQ_STAT, 0);
      chk_val("wake stat", 32'h0000_0005, rdata);
      apb(1'b0, `ICU_OFS_IRQ_MASK, 0);
      chk_val("wake mask", 32'h0000_0004, rdata);
      apb(1'b0, `ICU_OFS_CTRL, 0);
      chk_val("wake ctrl", 32'h0000_0007, rdata);
      sleep <= 1'b0;
      apb(1'b1, `ICU_OFS_IRQ_STAT, 32'h0000_0007);
      apb(1'b1, `ICU_OFS_CTRL, 32'h0000_0003);
      apb(1'b1, `ICU_OFS_PWR, 32'h0000_0001);
      apb(1'b1, `ICU_OFS_CTRL, 32'h0000_0000);
      apb(1'b0, `ICU_OFS_CTRL, 0);
      chk_val("off read", 0, rdata);
      tog(2);
      apb(1'b1, `ICU_OFS_PWR, 32'h0000_0000);
      apb(1'b0, `ICU_OFS_CTRL, 0);
      chk_val("on again", 32'h0000_0003, rdata);
      apb(1'b0, 12'h020, 0);
      chk_val("unmapped", 1, slverr);
      report_and_stop;
   end
endmodule
`default_nettype wire
